// ===== rtl/smseq_map.svh
// constants for the supply monitor sequencer
// assumes inclusion by the sequencer module only
`ifndef SMSEQ_MAP_SVH
`define SMSEQ_MAP_SVH
`define SMSEQ_WARN_VECTOR      8'h2B
`define SMSEQ_STROBE_INACTIVE  1'b1
`define SMSEQ_SYNC_RESET       3'h0
`define SMSEQ_SYNC_LOW_RESET   3'h7
`define SMSEQ_LEVELS_RESET     3'h2 // warn clear, below minimum, above backup
`define SMSEQ_VECTOR_RESET     8'h00
`endif

// ===== rtl/smseq_pkg.sv
// types for the supply monitor sequencer
// assumes no other package
package smseq_pkg;
   // synchronised comparator levels
   typedef struct packed
   {
      logic warn;
      logic below_min;
      logic below_backup;
   } smseq_levels_type;

   // sequencer states, one-hot
   typedef enum logic [3:0]
   {
      SMSEQ_RUN     = 4'h1,
      SMSEQ_WARN    = 4'h2,
      SMSEQ_RESET   = 4'h4,
      SMSEQ_BACKUP  = 4'h8
   } smseq_state_type;
endpackage

// ===== rtl/smseq_sequencer.sv
// supply-fall sequencer: warning interrupt, low-supply reset, backup switchover
// assumes comparator levels arrive asynchronously; one clock at 25 MHz
// Notes on behaviour
// - early warning vectors interrupt to 2Bh
// - warning never halts or resets processor
// - minimum level holds reset until recovery
// - reset drives chip enables, strobe high
// - below backup threshold, switch to cell
// - backup keeps nonvolatile state bits unchanged
`timescale 1ns/1ps
`include "smseq_map.svh"
module smseq_sequencer
#(
   parameter int CE_COUNT = 4,
   parameter int NV_WIDTH = 8
)
(
   input  wire logic                clock,
   input  wire logic                nrst,
   input  wire logic                early_warning_threshold,
   input  wire logic                minimum_operating_level,
   input  wire logic                backup_switchover_threshold,
   input  wire logic                warn_int_enable,
   input  wire logic                warn_int_ack,
   input  wire logic [CE_COUNT-1:0] ce_n_in,
   input  wire logic                rw_n_in,
   input  wire logic                nv_write,
   input  wire logic [NV_WIDTH-1:0] nv_data_in,
   output logic                     warn_int_req,
   output logic [7:0]               warn_int_vector,
   output logic                     cpu_reset,
   output logic [CE_COUNT-1:0]      ce_n_out,
   output logic                     rw_n_out,
   output logic                     on_backup,
   output logic                     external_memory_supply_out,
   output logic [NV_WIDTH-1:0]      nv_state
);

   // refuse sizes the logic cannot serve
   if (CE_COUNT < 1 || NV_WIDTH < 1)
   begin : gen_bad_params
      $error("bad parameters");
   end

   // --------------------------------------------------------
   // input synchronisers
   // --------------------------------------------------------
   logic [2:0] sync_warn;
   logic [2:0] sync_min;
   logic [2:0] sync_bak;
   smseq_pkg::smseq_levels_type lv;

   // three stages each; a change counts when stages two and three agree
   // minimum level starts asserted, so reset holds until it reads clear
   // synchronised level inputs
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         sync_warn <= `SMSEQ_SYNC_RESET;
         sync_min  <= `SMSEQ_SYNC_LOW_RESET;
         sync_bak  <= `SMSEQ_SYNC_RESET;
      end
      else
      begin
         sync_warn <= {sync_warn[1:0], early_warning_threshold};
         sync_min  <= {sync_min[1:0], minimum_operating_level};
         sync_bak  <= {sync_bak[1:0], backup_switchover_threshold};
      end
   end

   // filtered levels, held while stages two and three disagree
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         lv <= `SMSEQ_LEVELS_RESET;
      else
      begin
         if (sync_warn[1] == sync_warn[2])
            lv.warn <= sync_warn[2];
         if (sync_min[1] == sync_min[2])
            lv.below_min <= sync_min[2];
         if (sync_bak[1] == sync_bak[2])
            lv.below_backup <= sync_bak[2];
      end
   end

   // --------------------------------------------------------
   // sequencer
   // --------------------------------------------------------
   smseq_pkg::smseq_state_type state;
   smseq_pkg::smseq_state_type next_state;

   // low-supply states: processor held, strobes forced off
   function automatic logic smseq_is_low(input smseq_pkg::smseq_state_type s);
      return s == smseq_pkg::SMSEQ_RESET || s == smseq_pkg::SMSEQ_BACKUP;
   endfunction

   // deeper fall wins; reset released only once minimum clears
   always_comb
   begin
      case (state)
         smseq_pkg::SMSEQ_RUN,
         smseq_pkg::SMSEQ_WARN:
            if (lv.below_backup)
               next_state = smseq_pkg::SMSEQ_BACKUP;
            else if (lv.below_min)
               next_state = smseq_pkg::SMSEQ_RESET;
            else if (lv.warn)
               next_state = smseq_pkg::SMSEQ_WARN;
            else
               next_state = smseq_pkg::SMSEQ_RUN;
         smseq_pkg::SMSEQ_RESET,
         smseq_pkg::SMSEQ_BACKUP:
            if (lv.below_backup)
               next_state = smseq_pkg::SMSEQ_BACKUP;
            else if (lv.below_min)
               next_state = smseq_pkg::SMSEQ_RESET;
            else
               next_state = smseq_pkg::SMSEQ_RUN;
         default:
            next_state = smseq_pkg::SMSEQ_RESET;
      endcase
   end

   // state register, starts in reset
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         state <= smseq_pkg::SMSEQ_RESET;
      else
         state <= next_state;
   end

   // --------------------------------------------------------
   // warning interrupt
   // --------------------------------------------------------
   logic warn_seen;

   // one request per warning entry; set wins over acknowledge
   // vector to warning address
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         warn_int_req <= 1'b0;
         warn_seen    <= 1'b0;
      end
      else
      begin
         warn_seen <= lv.warn;
         if (lv.warn && !warn_seen && warn_int_enable && state == smseq_pkg::SMSEQ_RUN)
            warn_int_req <= 1'b1;
         else if (warn_int_ack || smseq_is_low(state))
            warn_int_req <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         warn_int_vector <= `SMSEQ_VECTOR_RESET;
      else
         warn_int_vector <= `SMSEQ_WARN_VECTOR;
   end

   // --------------------------------------------------------
   // reset, strobes and supply path
   // --------------------------------------------------------
   logic in_low;
   assign in_low = smseq_is_low(next_state);

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         cpu_reset                  <= 1'b1;
         ce_n_out                   <= {CE_COUNT{`SMSEQ_STROBE_INACTIVE}};
         rw_n_out                   <= `SMSEQ_STROBE_INACTIVE;
         on_backup                  <= 1'b0;
         external_memory_supply_out <= 1'b0;
      end
      else
      begin
         cpu_reset                  <= in_low;
         ce_n_out                   <= in_low ? {CE_COUNT{`SMSEQ_STROBE_INACTIVE}} : ce_n_in;
         rw_n_out                   <= in_low ? `SMSEQ_STROBE_INACTIVE : rw_n_in;
         on_backup                  <= next_state == smseq_pkg::SMSEQ_BACKUP;
         external_memory_supply_out <= next_state == smseq_pkg::SMSEQ_BACKUP;
      end
   end

   // --------------------------------------------------------
   // nonvolatile state, untouched by reset
   // --------------------------------------------------------
   // writes only while running
   always_ff @(posedge clock)
   begin
      if (nv_write && !cpu_reset && !in_low)
         nv_state <= nv_data_in;
   end

   // --------------------------------------------------------
   // checks
   // --------------------------------------------------------
   sequence low_seen_s;
      lv.below_min && !lv.below_backup;
   endsequence

   warn_vector_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(warn_int_req) |-> warn_int_vector == `SMSEQ_WARN_VECTOR && $past(warn_int_enable))
      else $error("warning request bad");
   warn_no_reset_a: assert property (@(posedge clock) disable iff (!nrst)
      state == smseq_pkg::SMSEQ_WARN |-> !cpu_reset)
      else $error("warning caused reset");
   low_reset_a: assert property (@(posedge clock) disable iff (!nrst)
      low_seen_s |=> cpu_reset)
      else $error("no reset at low supply");
   strobe_off_a: assert property (@(posedge clock) disable iff (!nrst)
      cpu_reset |-> rw_n_out && &ce_n_out)
      else $error("strobe active in reset");
   backup_switch_a: assert property (@(posedge clock) disable iff (!nrst)
      lv.below_backup |=> on_backup && external_memory_supply_out)
      else $error("no backup switch");
   nv_hold_a: assert property (@(posedge clock) disable iff (!nrst)
      on_backup && $past(on_backup) |=> $stable(nv_state))
      else $error("state lost in backup");
   release_late_a: assert property (@(posedge clock) disable iff (!nrst)
      $fell(cpu_reset) |-> !$past(lv.below_min) && !$past(lv.below_backup))
      else $error("early reset release");
   sync_delay_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(lv.below_min) |-> $past(sync_min[2]) && $past(sync_min[1]))
      else $error("unsynchronised level");
endmodule

// ===== tb/smseq_testbench.sv
// self-checking bench for the supply monitor sequencer
// assumes outputs settle within eight clocks of any level change
`timescale 1ns/1ps
module testbench;
   // one table row: comparator levels, then expected reset and backup
   typedef struct packed
   {
      logic warn;
      logic low;
      logic bk;
      logic exp_rst;
      logic exp_bk;
   } smseq_row_type;

   logic          clock  = 1'b0;
   logic          nrst   = 1'b0;
   logic          warn   = 1'b0;
   logic          low    = 1'b0;
   logic          bk     = 1'b0;
   logic          en     = 1'b0;
   logic          ack    = 1'b0;
   logic          nv_wr  = 1'b0;
   logic [7:0]    nv_din = 8'h00;
   logic [3:0]    ce_in  = 4'hA;
   logic          rw_in  = 1'b0;
   logic          req;
   logic [7:0]    vec;
   logic          rst;
   logic [3:0]    ce_n;
   logic          rw_n;
   logic          on_bk;
   logic          vcco;
   logic [7:0]    nv;
   logic          r;
   logic          b;
   int            n_fail = 0;
   int            checks = 0;
   int            cycles = 0;
   smseq_row_type rows [8] = '{5'b00000, 5'b10000, 5'b11010, 5'b11111,
                               5'b11010, 5'b00000, 5'b00111, 5'b00000};

   // ----------------------------------------
   // clock, timeout, design
   // ----------------------------------------
   initial
   begin
      forever #20 clock = ~clock;
   end

   // cut a hang short
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 1000)
      begin
         n_fail++;
         print_verdict();
      end
   end

   smseq_sequencer #(.CE_COUNT(4), .NV_WIDTH(8)) dut
   (
      .clock                       (clock),
      .nrst                        (nrst),
      .early_warning_threshold     (warn),
      .minimum_operating_level     (low),
      .backup_switchover_threshold (bk),
      .warn_int_enable             (en),
      .warn_int_ack                (ack),
      .ce_n_in                     (ce_in),
      .rw_n_in                     (rw_in),
      .nv_write                    (nv_wr),
      .nv_data_in                  (nv_din),
      .warn_int_req                (req),
      .warn_int_vector             (vec),
      .cpu_reset                   (rst),
      .ce_n_out                    (ce_n),
      .rw_n_out                    (rw_n),
      .on_backup                   (on_bk),
      .external_memory_supply_out  (vcco),
      .nv_state                    (nv)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic settle();
      repeat (8) @(negedge clock);
   endtask

   task automatic nv_put(input logic [7:0] d);
      nv_din = d;
      nv_wr  = 1'b1;
      @(negedge clock);
      nv_wr  = 1'b0;
      settle();
   endtask

   task automatic print_verdict();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      repeat (4) @(negedge clock);
      chk({rst, on_bk, vcco, rw_n, ce_n}, 8'h9F);
      nrst = 1'b1;
      settle();
      // nonvolatile state written while running
      nv_put(8'hC3);
      chk(nv, 8'hC3);
      // table of supply levels
      foreach (rows[i])
      begin
         {warn, low, bk} = rows[i][4:2];
         rw_in = i[0];
         settle();
         r = rows[i].exp_rst;
         b = rows[i].exp_bk;
         chk({rst, on_bk, vcco, rw_n, ce_n}, {r, b, b, r | rw_in, ce_in | {4{r}}});
      end
      $display("test table done");
      // warning interrupt, ack, disabled case
      en   = 1'b1;
      warn = 1'b1;
      settle();
      chk(vec, 8'h2B);
      chk({6'h00, req, rst}, 8'h02);
      ack  = 1'b1;
      @(negedge clock);
      ack  = 1'b0;
      settle();
      chk({7'h00, req}, 8'h00);
      warn = 1'b0;
      en   = 1'b0;
      settle();
      warn = 1'b1;
      settle();
      chk({7'h00, req}, 8'h00);
      // low supply withdraws a pending request
      warn = 1'b0;
      en   = 1'b1;
      settle();
      warn = 1'b1;
      settle();
      chk({7'h00, req}, 8'h01);
      low  = 1'b1;
      settle();
      chk({6'h00, req, rst}, 8'h01);
      warn = 1'b0;
      low  = 1'b0;
      en   = 1'b0;
      settle();
      $display("test warning done");
      // nonvolatile state kept through backup
      nv_put(8'hA5);
      chk(nv, 8'hA5);
      bk = 1'b1;
      settle();
      nv_put(8'h5A);
      chk(nv, 8'hA5);
      bk = 1'b0;
      settle();
      chk({7'h00, rst}, 8'h00);
      $display("test backup done");
      // reset again in mid-run
      nrst = 1'b0;
      @(negedge clock);
      chk({rst, on_bk, vcco, rw_n, ce_n}, 8'h9F);
      nrst = 1'b1;
      settle();
      chk({7'h00, rst}, 8'h00);
      chk(nv, 8'hA5);
      $display("test reset done");
      print_verdict();
   end
endmodule
